//--- rtl/tcm_timer8.sv
/*
 * 8-bit timer counter with output compare, normal and clear-on-match
 * counting, compare buffering, force strobe and write blocking.
 * Assumes all inputs synchronous to clock_i and a prescaled tick
 * arriving as a one-cycle enable on timer_tick_i.
 */
module tcm_timer8
    import tcm_pkg::*;
(
    input  wire logic       clock_i,          // System clock
    input  wire logic       sys_rst_i,        // Sync reset, high
    input  wire logic       timer_tick_i,     // Prescaled tick
    input  wire logic [2:0] clock_source_select_i, // Zero stops
    input  wire logic       ctrl_wr_i,        // Control write
    input  wire logic [1:0] waveform_mode_bits_i, // Mode data
    input  wire logic [1:0] compare_output_action_bits_i, // Action
    input  wire logic       compare_irq_enable_i, // Irq enable data
    input  wire logic       force_compare_strobe_i, // Force pulse
    input  wire logic       count_wr_i,       // Counter write
    input  wire logic [7:0] count_wdata_i,    // Counter data
    input  wire logic       compare_wr_i,     // Compare write
    input  wire logic [7:0] compare_wdata_i,  // Compare data
    input  wire logic       cmp_flag_wr1_i,   // Write one to flag
    input  wire logic       ovf_flag_wr1_i,   // Write one to flag
    input  wire logic       cmp_irq_ack_i,    // Compare irq served
    input  wire logic       ovf_irq_ack_i,    // Overflow irq served
    input  wire logic       port_out_bit_i,   // Ordinary port value
    input  wire logic       compare_pin_direction_bit_i, // 1 = out
    output logic [7:0]      timer_count_value_o, // Counter
    output logic [7:0]      compare_value_reg_o, // Compare readback
    output logic            compare_match_flag_o, // Match flag
    output logic            overflow_flag_o,  // Overflow flag
    output logic            compare_irq_o,    // Compare request
    output logic            compare_output_level_o, // Output reg
    output logic            pin_out_o,        // Pin output value
    output logic            pin_oe_o          // Pin output enable
);
    import tcm_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] count;        // Counter
    logic [7:0] cmp_active;   // Compare used by comparator
    logic [7:0] cmp_buf;      // Buffer for PWM modes
    logic [1:0] mode;         // Waveform mode
    logic [1:0] action;       // Compare output action
    logic       irq_en;       // Compare interrupt enable
    logic       oc_level;     // Compare output register
    logic       cmp_flag;     // Compare match flag
    logic       ovf_flag;     // Overflow flag
    logic       match_pend;   // Match waiting for next tick
    logic       blk_pend;     // Counter written, block next tick

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic       tick;         // Gated timer clock
    logic       pwm;          // PWM mode, buffering on
    logic       eq;           // Raw comparator output
    logic       match_ev;     // Unblocked match this tick
    logic       match_clr;    // Counter clear on match
    logic       wrap;         // Count passes max to zero
    logic       oc_event;     // Output update request
    logic [7:0] next_count;   // Counter next value
    logic       next_oc;      // Output next value

    // Timer stops on source zero
    assign tick = timer_tick_i && (clock_source_select_i != CS_STOPPED);
    assign pwm  = mode[MODE_PWM_B];
    assign eq   = (count == cmp_active);

    // Blocked during the tick after a counter write, or a write now
    assign match_ev = tick && eq && !blk_pend && !count_wr_i;

    // Sequence depends on mode only
    assign match_clr = (mode == MODE_CLEAR) && match_ev;
    assign wrap = tick && !count_wr_i && (count == CNT_MAX);

    // ------------------------------------------------------------
    // Counter next value
    // ------------------------------------------------------------
    always_comb begin
        if (count_wr_i) begin
            next_count = count_wdata_i;
        end else if (!tick) begin
            next_count = count;
        end else if (match_clr) begin
            next_count = CNT_BOTTOM;
        end else begin
            // Past a lowered compare it runs on to max and wraps
            next_count = count + 8'h01;
        end
    end

    // Counter register
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            count <= CNT_RST;
        end else begin
            count <= next_count;
        end
    end

    // ------------------------------------------------------------
    // Match blocking after a counter write
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            blk_pend <= 1'b0;
        end else if (count_wr_i) begin
            blk_pend <= 1'b1;
        end else if (tick) begin
            blk_pend <= 1'b0; // Held even with timer stopped
        end
    end

    // ------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            mode   <= MODE_RST;
            action <= ACT_NONE;
            irq_en <= 1'b0;
        end else if (ctrl_wr_i) begin
            mode   <= waveform_mode_bits_i;
            action <= compare_output_action_bits_i;
            irq_en <= compare_irq_enable_i;
        end
    end

    // ------------------------------------------------------------
    // Compare value and its buffer
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cmp_buf <= CMP_RST;
        end else if (compare_wr_i) begin
            cmp_buf <= compare_wdata_i;
        end
    end

    // Active compare: direct write, or buffer copy at top or bottom
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cmp_active <= CMP_RST;
        end else if (!pwm && compare_wr_i) begin
            cmp_active <= compare_wdata_i;
        end else if (pwm && tick &&
                     (count == CNT_MAX || count == CNT_BOTTOM)) begin
            cmp_active <= cmp_buf;
        end
    end

    // Readback follows the register software targets
    assign compare_value_reg_o = pwm ? cmp_buf : cmp_active;

    // ------------------------------------------------------------
    // Compare match flag
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            match_pend <= 1'b0;
        end else if (match_ev) begin
            match_pend <= 1'b1;
        end else if (tick) begin
            match_pend <= 1'b0;
        end
    end

    // Set wins over clear in the same cycle
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cmp_flag <= 1'b0;
        end else if (match_pend && tick) begin
            cmp_flag <= 1'b1;
        end else if (cmp_irq_ack_i || cmp_flag_wr1_i) begin
            cmp_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Overflow flag
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ovf_flag <= 1'b0;
        end else if (wrap && !pwm) begin
            ovf_flag <= 1'b1;
        end else if (ovf_irq_ack_i || ovf_flag_wr1_i) begin
            ovf_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Compare output register
    // ------------------------------------------------------------
    // Real match or force strobe, only outside PWM modes
    assign oc_event = !pwm && (match_ev || force_compare_strobe_i);

    always_comb begin
        next_oc = oc_level;
        if (oc_event) begin
            case (action)
                ACT_TOGGLE: next_oc = !oc_level;
                ACT_CLEAR:  next_oc = 1'b0;
                ACT_SET:    next_oc = 1'b1;
                default:    next_oc = oc_level;
            endcase
        end
    end

    // Mode writes never touch this register
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            oc_level <= 1'b0;
        end else begin
            oc_level <= next_oc;
        end
    end

    // ------------------------------------------------------------
    // Outputs and pin override
    // ------------------------------------------------------------
    assign timer_count_value_o    = count;
    assign compare_match_flag_o   = cmp_flag;
    assign overflow_flag_o        = ovf_flag;
    assign compare_irq_o          = cmp_flag && irq_en;
    assign compare_output_level_o = oc_level;
    assign pin_out_o = (action != ACT_NONE) ? oc_level : port_out_bit_i;
    assign pin_oe_o  = compare_pin_direction_bit_i;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    // Match then a tick in the next cycle
    sequence s_match;
        match_ev;
    endsequence
    sequence s_next_tick;
        tick;
    endsequence

    a_flag_after_match: assert property (
        s_match ##1 s_next_tick |=> cmp_flag)
        else $error("Flag not set on tick after match");

    a_flag_not_same: assert property (
        s_match ##0 (!cmp_flag && !match_pend) |=> !cmp_flag)
        else $error("Flag set in match cycle");

    a_irq_gate: assert property (
        compare_irq_o == (compare_match_flag_o && irq_en))
        else $error("Interrupt gating wrong");

    a_flag_clear: assert property (
        cmp_flag && cmp_flag_wr1_i && !(match_pend && tick) |=> !cmp_flag)
        else $error("Flag clear by write one failed");

    a_block_write: assert property (
        count_wr_i ##1 (!count_wr_i && tick) |-> !match_ev)
        else $error("Match not blocked after write");

    // Blocking survives a stopped timer until the next tick
    a_block_gap: assert property (
        count_wr_i ##1 (!count_wr_i && !tick) ##1 (!count_wr_i && tick) |-> !match_ev)
        else $error("Match not blocked across stopped timer");

    a_write_wins: assert property (
        count_wr_i |=> count == $past(count_wdata_i))
        else $error("Counter write lost");

    a_stop_holds: assert property (
        clock_source_select_i == CS_STOPPED && !count_wr_i |=> $stable(count))
        else $error("Counter moved while stopped");

    a_match_clear: assert property (
        match_clr |=> count == CNT_BOTTOM)
        else $error("Clear-on-match did not clear");

    a_normal_inc: assert property (
        mode == MODE_NORMAL && tick && !count_wr_i
        |=> count == $past(count) + 8'h01)
        else $error("Normal mode did not increment");

    a_ovf_set: assert property (
        wrap && !pwm |=> ovf_flag && count == CNT_BOTTOM)
        else $error("Overflow flag not set at wrap");

    a_force_noflag: assert property (
        force_compare_strobe_i && !match_ev && !match_pend && !cmp_flag
        |=> !cmp_flag)
        else $error("Force strobe set the flag");

    a_toggle: assert property (
        oc_event && action == ACT_TOGGLE |=> oc_level != $past(oc_level))
        else $error("Toggle did not invert output");

    a_set_clear: assert property (
        oc_event && (action == ACT_SET || action == ACT_CLEAR)
        |=> oc_level == ($past(action) == ACT_SET))
        else $error("Set or clear action wrong");

    a_none_hold: assert property (
        action == ACT_NONE |=> $stable(oc_level))
        else $error("Output changed with no action");

    a_pin_mux: assert property (
        action != ACT_NONE |-> pin_out_o == oc_level)
        else $error("Pin not overridden");

    a_buffer_load: assert property (
        pwm && tick && count != CNT_MAX && count != CNT_BOTTOM
        |=> $stable(cmp_active))
        else $error("Buffered compare loaded mid count");

endmodule : tcm_timer8

//--- rtl/tcm_pkg.sv
/*
 * Constants for the 8-bit timer compare and clear-on-match block.
 * Assumes one system clock; the timer tick is a one-cycle enable.
 */
package tcm_pkg;
    // ------------------------------------------------------------
    // Counter values
    // ------------------------------------------------------------
    localparam logic [7:0] CNT_BOTTOM = 8'h00; // Bottom of count
    localparam logic [7:0] CNT_MAX    = 8'hff; // Maximum of count
    localparam logic [7:0] CNT_RST    = 8'h00; // Counter reset value
    localparam logic [7:0] CMP_RST    = 8'h00; // Compare reset value

    // ------------------------------------------------------------
    // Waveform modes (bit 0 set marks a PWM mode)
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_NORMAL = 2'h0; // Free running up count
    localparam logic [1:0] MODE_CLEAR  = 2'h2; // Clear on match
    localparam int         MODE_PWM_B  = 0;    // Bit that marks PWM
    localparam logic [1:0] MODE_RST    = 2'h0; // Mode reset value

    // ------------------------------------------------------------
    // Compare output actions
    // ------------------------------------------------------------
    localparam logic [1:0] ACT_NONE   = 2'h0; // Leave output alone
    localparam logic [1:0] ACT_TOGGLE = 2'h1; // Invert on match
    localparam logic [1:0] ACT_CLEAR  = 2'h2; // Clear on match
    localparam logic [1:0] ACT_SET    = 2'h3; // Set on match

    // ------------------------------------------------------------
    // Clock source select
    // ------------------------------------------------------------
    localparam logic [2:0] CS_STOPPED = 3'h0; // No timer clock
endpackage : tcm_pkg

//--- bench/testbench.sv
/*
 * Self-checking bench for the 8-bit timer compare block, with a cycle model.
 * Assumes tcm_pkg and tcm_timer8 are compiled first; one 20 MHz clock.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import tcm_pkg::*;
    // ------------------------------------------------------------
    // Stimulus, outputs and model state
    // ------------------------------------------------------------
    logic       clock_i = 1'b0, sys_rst_i = 1'b1, tick = 1'b0, ctrl_wr = 1'b0;  // Drives
    logic       ien = 1'b0, force_s = 1'b0, count_wr = 1'b0, compare_wr = 1'b0; // Pulses
    logic       cw1 = 1'b0, ow1 = 1'b0, cack = 1'b0, oack = 1'b0;                 // Clears
    logic       port = 1'b0, dir = 1'b0;                                          // Pin side
    logic [2:0] cs = 3'h0;                                                        // Source
    logic [1:0] wmode = 2'h0, wact = 2'h0;                                        // Control data
    logic [7:0] cdata = 8'h00, kdata = 8'h00;                                     // Write data
    logic [7:0] cnt_o, cmp_o;                                                     // Design values
    logic       flg_o, ovf_o, irq_o, lvl_o, pin_o, oe_o;                          // Design bits
    logic [7:0] m_cnt, m_cmp, m_buf;                                              // Model regs
    logic       m_flg, m_ovf, m_ocr, m_ien, m_pend, m_blk, m_bok;                 // Model bits
    logic [1:0] m_mode, m_act;                                                    // Model control
    int         errors = 0, n_compared = 0;                                       // Counters

    always #25 clock_i = ~clock_i;  // 50 ns period

    tcm_timer8 dut_u (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .timer_tick_i(tick),
        .clock_source_select_i(cs), .ctrl_wr_i(ctrl_wr), .waveform_mode_bits_i(wmode),
        .compare_output_action_bits_i(wact), .compare_irq_enable_i(ien),
        .force_compare_strobe_i(force_s), .count_wr_i(count_wr), .count_wdata_i(kdata),
        .compare_wr_i(compare_wr), .compare_wdata_i(cdata), .cmp_flag_wr1_i(cw1),
        .ovf_flag_wr1_i(ow1), .cmp_irq_ack_i(cack), .ovf_irq_ack_i(oack),
        .port_out_bit_i(port), .compare_pin_direction_bit_i(dir),
        .timer_count_value_o(cnt_o), .compare_value_reg_o(cmp_o),
        .compare_match_flag_o(flg_o), .overflow_flag_o(ovf_o), .compare_irq_o(irq_o),
        .compare_output_level_o(lvl_o), .pin_out_o(pin_o), .pin_oe_o(oe_o)
    );

    // ------------------------------------------------------------
    // Cycle model, updated on the same edge as the design
    // ------------------------------------------------------------
    always @(posedge clock_i) begin : model
        logic te, mt, pwm;
        te  = tick && (cs != CS_STOPPED);
        pwm = m_mode[MODE_PWM_B];
        mt  = te && !count_wr && !m_blk && (m_cnt == m_cmp);
        if (sys_rst_i) begin
            {m_cnt, m_cmp, m_buf} = '0;
            {m_flg, m_ovf, m_ocr, m_ien, m_pend, m_blk, m_bok, m_mode, m_act} = '0;
        end else begin
            m_flg  = (m_pend && te) || (m_flg && !cw1 && !cack);
            m_pend = (m_pend && !te) || mt;
            m_ovf  = (te && !count_wr && !pwm && m_cnt == CNT_MAX) || (m_ovf && !ow1 && !oack);
            if (!pwm && (mt || force_s)) begin
                case (m_act)
                    ACT_TOGGLE: m_ocr = !m_ocr;
                    ACT_CLEAR:  m_ocr = 1'b0;
                    ACT_SET:    m_ocr = 1'b1;
                    default:    m_ocr = m_ocr;
                endcase
            end
            if (pwm && te && (m_cnt == CNT_MAX || m_cnt == CNT_BOTTOM)) m_cmp = m_buf;
            if (compare_wr && pwm) begin
                m_buf = cdata;
                m_bok = 1'b1;
            end else if (compare_wr) m_cmp = cdata;
            if (count_wr) m_cnt = kdata;
            else if (te) m_cnt = (m_mode == MODE_CLEAR && mt) ? 8'h00 : m_cnt + 8'h01;
            if (count_wr) m_blk = 1'b1;
            else if (te) m_blk = 1'b0;
            if (ctrl_wr) {m_mode, m_act, m_ien} = {wmode, wact, ien};
        end
    end

    // ------------------------------------------------------------
    // Compare tasks and the step that checks every cycle
    // ------------------------------------------------------------
    task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h at %0t", name, e, g, $time);
        end
    endtask : chk8

    task automatic chk1(input string name, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %b seen %b at %0t", name, e, g, $time);
        end
    endtask : chk1

    task automatic step();
        @(negedge clock_i);
        chk8("count", m_cnt, cnt_o);
        if (!m_mode[MODE_PWM_B] || m_bok) begin
            chk8("compare", m_mode[MODE_PWM_B] ? m_buf : m_cmp, cmp_o);
        end
        chk1("match flag", m_flg, flg_o);
        chk1("overflow flag", m_ovf, ovf_o);
        chk1("compare irq", m_flg && m_ien, irq_o);
        chk1("output level", m_ocr, lvl_o);
        chk1("pin out", (m_act != ACT_NONE) ? m_ocr : port, pin_o);
        chk1("pin enable", dir, oe_o);
    endtask : step

    task automatic results();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results

    initial begin : watchdog
        #(50 * 40000);
        errors++;
        results();
    end

    // ------------------------------------------------------------
    // Main sequence: blocking, buffering, then random traffic
    // ------------------------------------------------------------
    initial begin : main
        void'($urandom(52));
        repeat (10) step();
        sys_rst_i = 1'b0;
        step();
        {ctrl_wr, wmode, wact, ien} = {1'b1, MODE_NORMAL, ACT_TOGGLE, 1'b1};
        step();
        ctrl_wr = 1'b0;
        kdata = 8'h33;
        count_wr = 1'b1;                 // Write while stopped
        step();
        count_wr = 1'b0;
        cdata = 8'h33;
        compare_wr = 1'b1;
        step();
        compare_wr = 1'b0;
        {cs, tick} = {3'h1, 1'b1};       // First tick must not match
        repeat (5) step();
        cs = CS_STOPPED;
        {ctrl_wr, wmode, wact} = {1'b1, 2'h1, ACT_NONE};
        step();
        ctrl_wr = 1'b0;
        cdata = 8'h80;
        compare_wr = 1'b1;                // Lands in buffer only
        step();
        compare_wr = 1'b0;
        cs = 3'h2;
        repeat (600) step();
        {ctrl_wr, wmode} = {1'b1, MODE_NORMAL};
        step();
        for (int i = 0; i < 30000; i++) begin
            sys_rst_i = (i >= 15000 && i < 15003);   // Mid-run reset
            tick = ($urandom % 4) != 0;
            if ($urandom % 64 == 0) cs = 3'($urandom % 8);
            ctrl_wr = ($urandom % 32) == 0;
            wmode = ($urandom % 2) ? MODE_CLEAR : MODE_NORMAL;
            wact = 2'($urandom);
            ien = 1'($urandom);
            force_s = ($urandom % 16) == 0;
            count_wr = ($urandom % 64) == 0;
            kdata = 8'($urandom);
            if (kdata == m_cmp) kdata = kdata + 8'h01;  // Never equal to compare
            compare_wr = !count_wr && !m_blk && ($urandom % 32) == 0;
            cdata = ($urandom % 2) ? 8'($urandom) : 8'($urandom % 16);
            {cw1, ow1, cack, oack} = {($urandom % 16) == 0, ($urandom % 16) == 0,
                                      ($urandom % 16) == 0, ($urandom % 16) == 0};
            port = 1'($urandom);
            dir = 1'($urandom);
            step();
        end
        results();
    end
endmodule : testbench
